/* design/bfm_map.vh */
/*
 constants for the bidirectional queue pair with mailboxes.
 assumes inclusion by bare name from the design files.
*/
`ifndef BFM_MAP_VH
`define BFM_MAP_VH
// ==========================================
// widths and depths
`define BFM_DATA_W 36
`define BFM_DEPTH 64
`define BFM_PTR_W 6
// ==========================================
// almost-flag offsets chosen at reset
`define BFM_OFS_HH 7'h10
`define BFM_OFS_HL 7'h0C
`define BFM_OFS_LH 7'h08
`define BFM_OFS_LL 7'h04
// ==========================================
// port b width codes {hi,lo}
`define BFM_SZ_LONG 2'h0
`define BFM_SZ_WORD 2'h1
`define BFM_SZ_BYTE 2'h2
`define BFM_SZ_MAIL 2'h3
// ==========================================
// byte lane fields
`define BFM_BYTE_W 9
`define BFM_WORD_W 18
`define BFM_UNITS_W 2
`endif

/* design/bfm_fifo.v */
/*
 generic synchronous fifo of parameterised width and depth.
 assumes one clock, synchronous active high reset, registered count.
*/
`timescale 1ns/10ps
module bfm_fifo #(
   parameter WIDTH = 36,
   parameter DEPTH = 64,
   parameter AW = 6
)(
   input wire clk_in,
   input wire rst_in,
   input wire in_valid_in,
   output wire in_ready_out,
   input wire [WIDTH-1:0] in_data_in,
   output wire out_valid_out,
   input wire out_ready_in,
   output wire [WIDTH-1:0] out_data_out,
   output wire [AW:0] count_out
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wp_q;
   reg [AW-1:0] rp_q;
   reg [AW:0] cnt_q;
   wire do_wr;
   wire do_rd;
   // ==========================================
   // handshake terms
   assign in_ready_out = (cnt_q != DEPTH[AW:0]);
   assign out_valid_out = (cnt_q != {(AW+1){1'b0}});
   assign do_wr = in_valid_in & in_ready_out;
   assign do_rd = out_valid_out & out_ready_in;
   assign out_data_out = mem[rp_q];
   assign count_out = cnt_q;
   // storage array
   always @(posedge clk_in)
   begin
      if (do_wr)
      begin
         mem[wp_q] <= in_data_in;
      end
   end
   // pointers and fill count
   always @(posedge clk_in)
   begin
      if (rst_in)
      begin
         wp_q <= {AW{1'b0}};
         rp_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (do_wr)
         begin
            wp_q <= wp_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_rd)
         begin
            rp_q <= rp_q + {{(AW-1){1'b0}}, 1'b1};
         end
         if (do_wr & ~do_rd)
         begin
            cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
         end
         else if (do_rd & ~do_wr)
         begin
            cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
         end
      end
   end
endmodule

/* design/bfm_top.v */
/*
 bidirectional queue pair with mailboxes and port b bus sizing.
 assumes ports a and b clocks are sampled by ref_clk_in, well slower.
*/
`timescale 1ns/10ps
`include "bfm_map.vh"
module bfm_top #(
   parameter DW = `BFM_DATA_W,
   parameter DEPTH = `BFM_DEPTH,
   parameter AW = `BFM_PTR_W
)(
   input wire ref_clk_in,
   input wire rst_in,
   input wire offset_select_lo_in,
   input wire offset_select_hi_in,
   input wire porta_clock_in,
   input wire porta_chip_select_n_in,
   input wire porta_write_not_read_in,
   input wire porta_enable_in,
   input wire porta_mailbox_select_in,
   input wire [DW-1:0] porta_data_in,
   output reg [DW-1:0] porta_data_out,
   output reg porta_data_oe_out,
   input wire portb_clock_in,
   input wire portb_chip_select_n_in,
   input wire portb_write_not_read_in,
   input wire portb_enable_in,
   input wire portb_width_select_lo_in,
   input wire portb_width_select_hi_in,
   input wire big_endian_select_n_in,
   input wire [DW-1:0] portb_data_in,
   output reg [DW-1:0] portb_data_out,
   output reg portb_data_oe_out,
   output reg mailbox1_full_n_out,
   output reg mailbox2_full_n_out,
   output reg porta_empty_n_out,
   output reg porta_almost_empty_n_out,
   output reg porta_almost_full_n_out,
   output reg porta_full_n_out,
   output reg portb_empty_n_out,
   output reg portb_almost_empty_n_out,
   output reg portb_almost_full_n_out,
   output reg portb_full_n_out
);
   localparam [AW:0] FULLC = DEPTH[AW:0];
   // ==========================================
   // input synchronisers, two stages each
   reg [11:0] sa1_q;
   reg [11:0] sa2_q;
   reg [DW-1:0] da1_q;
   reg [DW-1:0] da2_q;
   reg [DW-1:0] db1_q;
   reg [DW-1:0] db2_q;
   reg ca3_q;
   reg cb3_q;
   always @(posedge ref_clk_in)
   begin
      sa1_q <= {porta_clock_in, porta_chip_select_n_in, porta_write_not_read_in,
                porta_enable_in, porta_mailbox_select_in, portb_clock_in,
                portb_chip_select_n_in, portb_write_not_read_in, portb_enable_in,
                portb_width_select_lo_in, portb_width_select_hi_in,
                big_endian_select_n_in};
      sa2_q <= sa1_q;
      da1_q <= porta_data_in;
      da2_q <= da1_q;
      db1_q <= portb_data_in;
      db2_q <= db1_q;
      ca3_q <= sa2_q[11];
      cb3_q <= sa2_q[6];
   end
   wire a_edge = sa2_q[11] & ~ca3_q;
   wire b_edge = sa2_q[6] & ~cb3_q;
   wire a_csn = sa2_q[10];
   wire a_wr = sa2_q[9];
   wire a_en = sa2_q[8];
   wire a_mb = sa2_q[7];
   wire b_csn = sa2_q[5];
   wire b_wr = sa2_q[4];
   wire b_en = sa2_q[3];
   wire [1:0] b_sz_raw = {sa2_q[1], sa2_q[2]};
   wire b_ben_raw = sa2_q[0];
   // ==========================================
   // offset strap, caught while reset is held
   reg [6:0] ofs_q;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         case ({offset_select_hi_in, offset_select_lo_in})
            2'h3: ofs_q <= `BFM_OFS_HH;
            2'h2: ofs_q <= `BFM_OFS_HL;
            2'h1: ofs_q <= `BFM_OFS_LH;
            default: ofs_q <= `BFM_OFS_LL;
         endcase
      end
   end
   // ==========================================
   // port b width select register
   reg [1:0] szq_q;
   reg benq_q;
   reg [1:0] szi_q;
   reg beni_q;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         szq_q <= `BFM_SZ_LONG;
         benq_q <= 1'b1;
         szi_q <= `BFM_SZ_LONG;
         beni_q <= 1'b1;
      end
      else if (b_edge)
      begin
         szq_q <= b_sz_raw;
         benq_q <= b_ben_raw;
         if (~b_csn & b_en & (b_sz_raw != `BFM_SZ_MAIL) & (szq_q != `BFM_SZ_MAIL))
         begin
            szi_q <= szq_q; // width of the last queue transfer
            beni_q <= benq_q;
         end
      end
   end
   wire b_mail = (b_sz_raw == `BFM_SZ_MAIL);
   // width in force at this edge; mailbox access keeps the prior one
   wire [1:0] sz_eff = (szq_q == `BFM_SZ_MAIL) ? szi_q : szq_q;
   wire ben_eff = (szq_q == `BFM_SZ_MAIL) ? beni_q : benq_q;
   // ==========================================
   // transfer qualification per port
   wire a_sel = a_edge & ~a_csn & a_en;
   wire b_sel = b_edge & ~b_csn & b_en;
   wire a_mw = a_sel & a_wr & a_mb;
   wire a_mr = a_sel & ~a_wr & a_mb;
   wire a_qw = a_sel & a_wr & ~a_mb;
   wire a_qr = a_sel & ~a_wr & ~a_mb;
   wire b_mw = b_sel & b_wr & b_mail;
   wire b_mr = b_sel & ~b_wr & b_mail;
   wire b_qw = b_sel & b_wr & ~b_mail;
   wire b_qr = b_sel & ~b_wr & ~b_mail;
   // ==========================================
   // mailboxes, stored unsized
   reg [DW-1:0] mb1_q;
   reg [DW-1:0] mb2_q;
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         mailbox1_full_n_out <= 1'b1;
         mailbox2_full_n_out <= 1'b1;
         mb1_q <= {DW{1'b0}};
         mb2_q <= {DW{1'b0}};
      end
      else
      begin
         if (a_mw & mailbox1_full_n_out)
         begin
            mb1_q <= da2_q;
            mailbox1_full_n_out <= 1'b0;
         end
         else if (b_mr)
         begin
            mailbox1_full_n_out <= 1'b1;
         end
         if (b_mw & mailbox2_full_n_out)
         begin
            mb2_q <= db2_q;
            mailbox2_full_n_out <= 1'b0;
         end
         else if (a_mr)
         begin
            mailbox2_full_n_out <= 1'b1;
         end
      end
   end
   // ==========================================
   // queue 1 (a to b) and queue 2 (b to a)
   wire q1_ir;
   wire q1_ov;
   wire [DW-1:0] q1_d;
   wire [AW:0] q1_c;
   wire q2_ir;
   wire q2_ov;
   wire [DW-1:0] q2_d;
   wire [AW:0] q2_c;
   reg [1:0] unit_q;
   reg [DW-1:0] aux_q;
   reg [1:0] wunit_q;
   reg [DW-1:0] waux_q;
   wire b_narrow = (sz_eff != `BFM_SZ_LONG);
   wire [1:0] last_u = (sz_eff == `BFM_SZ_BYTE) ? 2'h3 : 2'h1;
   // fresh long word when no units remain or width changed
   wire b_fetch = b_qr & ((unit_q == 2'h0) | (sz_eff != szi_q));
   wire q1_pop = b_fetch & q1_ov;
   wire a_push = a_qw & q1_ir;
   // narrow write completes on last unit
   wire wfresh = (sz_eff != szi_q) | (wunit_q == 2'h0);
   wire [1:0] wu = wfresh ? 2'h0 : wunit_q;
   wire b_wlast = ~b_narrow | (wu == last_u);
   wire b_push = b_qw & b_wlast & q2_ir;
   wire a_pop = a_qr & q2_ov;
   // byte lanes of a word, big endian takes high lanes first
   function [DW-1:0] lane_pos;
      input [DW-1:0] w;
      input [1:0] sz;
      input ben;
      input [1:0] u;
      reg [DW-1:0] r;
      begin
         r = w;
         if (sz == `BFM_SZ_WORD)
         begin
            r = ben ? (w >> (u[0] ? `BFM_WORD_W : 0)) :
                      (w >> (u[0] ? 0 : `BFM_WORD_W));
         end
         else if (sz == `BFM_SZ_BYTE)
         begin
            r = ben ? (w >> (`BFM_BYTE_W * u)) : (w >> (`BFM_BYTE_W * (2'h3 - u)));
         end
         lane_pos = r;
      end
   endfunction
   bfm_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_q1 (
      .clk_in(ref_clk_in), .rst_in(rst_in),
      .in_valid_in(a_push), .in_ready_out(q1_ir), .in_data_in(da2_q),
      .out_valid_out(q1_ov), .out_ready_in(q1_pop), .out_data_out(q1_d),
      .count_out(q1_c)
   );
   reg [DW-1:0] wasm;
   // assemble narrow writes into one long word
   always @*
   begin
      wasm = wfresh ? {DW{1'b0}} : waux_q;
      if (sz_eff == `BFM_SZ_WORD)
      begin
         if (ben_eff != (wu == 2'h0))
            wasm[DW-1:`BFM_WORD_W] = db2_q[`BFM_WORD_W-1:0];
         else
            wasm[`BFM_WORD_W-1:0] = db2_q[`BFM_WORD_W-1:0];
      end
      else if (sz_eff == `BFM_SZ_BYTE)
      begin
         wasm[`BFM_BYTE_W*(ben_eff ? wu : 2'h3 - wu) +: `BFM_BYTE_W] =
            db2_q[`BFM_BYTE_W-1:0];
      end
      else
      begin
         wasm = db2_q;
      end
   end
   bfm_fifo #(.WIDTH(DW), .DEPTH(DEPTH), .AW(AW)) u_q2 (
      .clk_in(ref_clk_in), .rst_in(rst_in),
      .in_valid_in(b_push), .in_ready_out(q2_ir), .in_data_in(wasm),
      .out_valid_out(q2_ov), .out_ready_in(a_pop), .out_data_out(q2_d),
      .count_out(q2_c)
   );
   // ==========================================
   // port b narrow read and write sequencing
   reg [DW-1:0] b_oreg_q;
   reg [DW-1:0] a_oreg_q;
   wire [DW-1:0] src_w = b_fetch ? q1_d : aux_q;
   wire [1:0] ru = b_fetch ? 2'h0 : unit_q;
   wire [DW-1:0] piece = lane_pos(src_w, sz_eff, ben_eff, ru);
   wire can_rd = b_fetch ? q1_ov : (unit_q != 2'h0);
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         unit_q <= 2'h0;
         aux_q <= {DW{1'b0}};
         wunit_q <= 2'h0;
         waux_q <= {DW{1'b0}};
         b_oreg_q <= {DW{1'b0}};
         a_oreg_q <= {DW{1'b0}};
      end
      else
      begin
         if (b_qr & can_rd)
         begin
            if (b_fetch)
               aux_q <= q1_d;
            if (~b_narrow)
               b_oreg_q <= q1_d;
            else if (sz_eff == `BFM_SZ_WORD)
               b_oreg_q[`BFM_WORD_W-1:0] <= piece[`BFM_WORD_W-1:0];
            else
               b_oreg_q[`BFM_BYTE_W-1:0] <= piece[`BFM_BYTE_W-1:0];
            unit_q <= (~b_narrow | (ru == last_u)) ? 2'h0 : ru + 2'h1;
         end
         if (b_qw & (q2_ir | ~b_wlast))
         begin
            waux_q <= wasm;
            wunit_q <= b_wlast ? 2'h0 : wu + 2'h1;
         end
         if (a_pop)
            a_oreg_q <= q2_d;
      end
   end
   // ==========================================
   // flag levels, then two stages on port clock edges
   wire [AW:0] q1_eff = q1_c + {{AW{1'b0}}, (unit_q != 2'h0)};
   wire [AW:0] ofs_w = ofs_q[AW:0];
   reg [3:0] fa1_q;
   reg [3:0] fa2_q;
   reg [3:0] fb1_q;
   reg [3:0] fb2_q;
   // {empty_n, almost_empty_n, almost_full_n, full_n}
   wire [3:0] fa_raw = {q2_c != 7'h00, q2_c > ofs_w, q1_c < (FULLC - ofs_w), q1_c != FULLC};
   wire [3:0] fb_raw = {q1_eff != 7'h00, q1_c > ofs_w, q2_c < (FULLC - ofs_w),
                        q2_c != FULLC};
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         fa1_q <= 4'h3;
         fa2_q <= 4'h3;
         fb1_q <= 4'h3;
         fb2_q <= 4'h3;
      end
      else
      begin
         if (a_edge)
         begin
            fa1_q <= fa_raw;
            fa2_q <= fa1_q;
         end
         if (b_edge)
         begin
            fb1_q <= fb_raw;
            fb2_q <= fb1_q;
         end
      end
   end
   // ==========================================
   // outputs, all registered
   always @(posedge ref_clk_in)
   begin
      if (rst_in)
      begin
         porta_data_out <= {DW{1'b0}};
         portb_data_out <= {DW{1'b0}};
         porta_data_oe_out <= 1'b0;
         portb_data_oe_out <= 1'b0;
         {porta_empty_n_out, porta_almost_empty_n_out} <= 2'h0;
         {porta_almost_full_n_out, porta_full_n_out} <= 2'h3;
         {portb_empty_n_out, portb_almost_empty_n_out} <= 2'h0;
         {portb_almost_full_n_out, portb_full_n_out} <= 2'h3;
      end
      else
      begin
         porta_data_oe_out <= ~a_csn & ~a_wr;
         portb_data_oe_out <= ~b_csn & ~b_wr;
         porta_data_out <= a_mb ? mb2_q : a_oreg_q;
         portb_data_out <= b_mail ? mb1_q : b_oreg_q;
         porta_empty_n_out <= fa2_q[3] & fa_raw[3];
         porta_almost_empty_n_out <= fa2_q[2] & fa_raw[2];
         porta_almost_full_n_out <= fa2_q[1] & fa_raw[1];
         porta_full_n_out <= fa2_q[0] & fa_raw[0];
         portb_empty_n_out <= fb2_q[3] & fb_raw[3];
         portb_almost_empty_n_out <= fb2_q[2] & fb_raw[2];
         portb_almost_full_n_out <= fb2_q[1] & fb_raw[1];
         portb_full_n_out <= fb2_q[0] & fb_raw[0];
      end
   end
   // mailbox reads drive a copy and release the full flag; contents untouched
endmodule

/* verif/bfm_top_assertions.sv */
/*
 concurrent checks on the ports of the queue pair top.
 assumes port controls are held across each port clock edge.
*/
`timescale 1ns/10ps
module bfm_top_checker (
   input wire ref_clk_in,
   input wire rst_in,
   input wire porta_chip_select_n_in,
   input wire porta_write_not_read_in,
   input wire porta_enable_in,
   input wire porta_mailbox_select_in,
   input wire porta_data_oe_out,
   input wire portb_chip_select_n_in,
   input wire portb_write_not_read_in,
   input wire portb_enable_in,
   input wire portb_width_select_lo_in,
   input wire portb_width_select_hi_in,
   input wire portb_data_oe_out,
   input wire mailbox1_full_n_out,
   input wire mailbox2_full_n_out,
   input wire porta_empty_n_out,
   input wire porta_almost_empty_n_out,
   input wire portb_empty_n_out,
   input wire portb_almost_empty_n_out
);
   // ==========================================
   // clocking and access sequences
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (rst_in);
   sequence a_off_s;
      (porta_chip_select_n_in || porta_write_not_read_in) [*5];
   endsequence
   sequence a_on_s;
      (!porta_chip_select_n_in && !porta_write_not_read_in) [*5];
   endsequence
   sequence b_off_s;
      (portb_chip_select_n_in || portb_write_not_read_in) [*5];
   endsequence
   sequence a_mail_s;
      !porta_chip_select_n_in && porta_enable_in && porta_mailbox_select_in;
   endsequence
   sequence b_mail_s;
      !portb_chip_select_n_in && portb_enable_in && portb_width_select_lo_in
         && portb_width_select_hi_in;
   endsequence
   // ==========================================
   // output drive
   AST_A_OFF: assert property (a_off_s |-> !porta_data_oe_out)
      else $error("port a drives while deselected");
   AST_A_ON: assert property (a_on_s |-> porta_data_oe_out)
      else $error("port a idle while read selected");
   AST_B_OFF: assert property (b_off_s |-> !portb_data_oe_out)
      else $error("port b drives while deselected");
   // ==========================================
   // mailbox flags
   AST_MB1_SET: assert property (
      $fell(mailbox1_full_n_out) |-> a_mail_s and porta_write_not_read_in)
      else $error("mail1 flag fell without port a mail write");
   AST_MB1_CLR: assert property (
      $rose(mailbox1_full_n_out) |-> b_mail_s and !portb_write_not_read_in)
      else $error("mail1 flag rose without port b mail read");
   AST_MB2_SET: assert property (
      $fell(mailbox2_full_n_out) |-> b_mail_s and portb_write_not_read_in)
      else $error("mail2 flag fell without port b mail write");
   AST_MB2_CLR: assert property (
      $rose(mailbox2_full_n_out) |-> a_mail_s and !porta_write_not_read_in)
      else $error("mail2 flag rose without port a mail read");
   // ==========================================
   // flag encoding and reset state
   AST_A_NEST: assert property (!porta_empty_n_out |-> !porta_almost_empty_n_out)
      else $error("port a empty without almost empty");
   AST_B_NEST: assert property (!portb_empty_n_out |-> !portb_almost_empty_n_out)
      else $error("port b empty without almost empty");
   AST_RESET_STATE: assert property ($fell(rst_in) |-> mailbox1_full_n_out
      && mailbox2_full_n_out && !porta_empty_n_out && !portb_empty_n_out)
      else $error("state after reset wrong");
endmodule

bind bfm_top bfm_top_checker u_chk (.ref_clk_in, .rst_in, .porta_chip_select_n_in,
   .porta_write_not_read_in, .porta_enable_in, .porta_mailbox_select_in, .porta_data_oe_out,
   .portb_chip_select_n_in, .portb_write_not_read_in, .portb_enable_in,
   .portb_width_select_lo_in, .portb_width_select_hi_in, .portb_data_oe_out,
   .mailbox1_full_n_out, .mailbox2_full_n_out, .porta_empty_n_out,
   .porta_almost_empty_n_out, .portb_empty_n_out, .portb_almost_empty_n_out);

/* verif/bfm_far_side.sv */
/*
 far-side processor clocks for ports a and b.
 assumes both clocks run free at 125 ns with unrelated phase.
*/
`timescale 1ns/10ps
module bfm_far_side #(
   parameter real PERIOD_NS = 125.0
)(
   output reg porta_clock_out,
   output reg portb_clock_out
);
   // ==========================================
   // port b clock, offset so it never lines up with port a
   initial
   begin
      porta_clock_out = 1'b0;
      portb_clock_out = 1'b0;
      #(37.3);
      forever
         #(PERIOD_NS / 2.0) portb_clock_out = ~portb_clock_out;
   end
   // port a clock
   always #(PERIOD_NS / 2.0) porta_clock_out = ~porta_clock_out;
endmodule

/* verif/bfm_top_tb_top.sv */
/*
 self-checking bench for the queue pair with mailboxes.
 assumes bfm_top, the checker bind and the far-side clock model.
*/
`timescale 1ns/10ps
`include "bfm_map.vh"
module bfm_top_tb_top;
   logic ref_clk, rst, fs_lo, fs_hi, pa_clk, pb_clk, ben;
   logic a_cs_n, a_wr, a_en, a_mb, b_cs_n, b_wr, b_en, b_lo, b_hi, b_be_n, a_oe, b_oe;
   logic mailbox1_full_n, mailbox2_full_n, a_ef, a_ae, a_af, a_ff, b_ef, b_ae, b_af, b_ff;
   logic [35:0] a_din, b_din, a_dout, b_dout, hold, mask, exp;
   int failures, comparisons, i, k, n, u, uw, nxt;
   logic [1:0] t_sz [7] = '{`BFM_SZ_WORD, `BFM_SZ_WORD, `BFM_SZ_BYTE, `BFM_SZ_BYTE,
      `BFM_SZ_WORD, `BFM_SZ_BYTE, `BFM_SZ_LONG};
   logic t_be [7] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
   int t_rd [7] = '{2, 2, 4, 4, 1, 1, 1};
   // ==========================================
   // design and far side
   bfm_far_side far (.porta_clock_out(pa_clk), .portb_clock_out(pb_clk));
   bfm_top dut (.ref_clk_in(ref_clk), .rst_in(rst), .offset_select_lo_in(fs_lo),
      .offset_select_hi_in(fs_hi), .porta_clock_in(pa_clk), .porta_chip_select_n_in(a_cs_n),
      .porta_write_not_read_in(a_wr), .porta_enable_in(a_en), .porta_mailbox_select_in(a_mb),
      .porta_data_in(a_din), .porta_data_out(a_dout), .porta_data_oe_out(a_oe),
      .portb_clock_in(pb_clk), .portb_chip_select_n_in(b_cs_n), .portb_write_not_read_in(b_wr),
      .portb_enable_in(b_en), .portb_width_select_lo_in(b_lo), .portb_width_select_hi_in(b_hi),
      .big_endian_select_n_in(b_be_n), .portb_data_in(b_din), .portb_data_out(b_dout),
      .portb_data_oe_out(b_oe), .mailbox1_full_n_out(mailbox1_full_n), .mailbox2_full_n_out(mailbox2_full_n),
      .porta_empty_n_out(a_ef), .porta_almost_empty_n_out(a_ae), .porta_almost_full_n_out(a_af),
      .porta_full_n_out(a_ff), .portb_empty_n_out(b_ef), .portb_almost_empty_n_out(b_ae),
      .portb_almost_full_n_out(b_af), .portb_full_n_out(b_ff));
   // reference clock
   always #5 ref_clk = ~ref_clk;
   // ==========================================
   // tasks
   function automatic logic [35:0] val(input int idx);
      val = 36'h9A5C3E1B7 ^ (idx * 36'h0F1E2D3C5);
   endfunction
   task check(input string what, input logic [35:0] seen, input logic [35:0] want);
      comparisons++;
      if (seen !== want)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, want, seen);
      end
   endtask
   // one port a transfer held across a single rising port a edge
   task xfer_a(input logic wr, input logic mb, input logic [35:0] d);
      @(negedge pa_clk);
      @(posedge ref_clk);
      a_cs_n <= 1'b0;
      a_wr <= wr;
      a_mb <= mb;
      a_en <= 1'b1;
      a_din <= d;
      @(negedge pa_clk);
      @(posedge ref_clk);
      a_en <= 1'b0;
      a_din <= ~d;
   endtask
   // one port b edge, enable chosen so an idle edge can load the width
   task xfer_b(input logic wr, input logic en, input logic [1:0] sz, input logic be,
      input logic [35:0] d);
      @(negedge pb_clk);
      @(posedge ref_clk);
      b_cs_n <= 1'b0;
      b_wr <= wr;
      b_en <= en;
      {b_hi, b_lo} <= sz;
      b_be_n <= be;
      b_din <= d;
      @(negedge pb_clk);
      @(posedge ref_clk);
      b_en <= 1'b0;
      b_din <= ~d;
   endtask
   task settle;
      repeat (4) @(posedge pa_clk);
      repeat (8) @(posedge ref_clk);
   endtask
   task do_reset(input logic [1:0] sel);
      {fs_hi, fs_lo} <= sel;
      rst <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
   endtask
   task close_out;
      $display("failures %0d comparisons %0d", failures, comparisons);
      if (failures == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // ==========================================
   // watchdog
   initial
   begin
      repeat (60000) @(posedge ref_clk);
      failures++;
      close_out;
   end
   // main sequence
   initial
   begin
      {ref_clk, rst, fs_lo, fs_hi, a_cs_n, a_wr, a_en, a_mb} = 8'h48;
      {b_cs_n, b_wr, b_en, b_lo, b_hi, b_be_n, a_din, b_din} = {6'h21, 72'h0};
      failures = 0;
      comparisons = 0;
      for (k = 0; k < 4; k++)
      begin
         do_reset(k[1:0]);
         check("reset flags", {mailbox1_full_n, mailbox2_full_n, b_ef, b_ae, a_af, a_ff, a_ef, a_ae, b_af, b_ff}, 10'h333);
         check("reset drive", {a_oe, b_oe}, 2'h0);
         for (i = 0; i < 4 * (k + 1); i++)
            xfer_a(1'b1, 1'b0, val(i));
         settle;
         check("flags at offset", {b_ef, b_ae}, 2'h2);
         xfer_a(1'b1, 1'b0, val(i));
         settle;
         check("flags past offset", {b_ef, b_ae}, 2'h3);
      end
      for (i = 17; i < 64; i++)
      begin
         xfer_a(1'b1, 1'b0, val(i));
         if (i == 46)
            settle;
         if (i == 46)
            check("below almost full", {a_af, a_ff}, 2'h3);
      end
      xfer_a(1'b1, 1'b0, 36'h0);
      settle;
      check("full", {a_af, a_ff}, 2'h0);
      xfer_b(1'b0, 1'b0, `BFM_SZ_LONG, 1'b1, 36'h0);
      for (i = 0; i < 17; i++)
      begin
         xfer_b(1'b0, 1'b1, `BFM_SZ_LONG, 1'b1, 36'h0);
         check("long read", b_dout, val(i));
         if (i == 0)
            check("full after read", a_ff, 1'b0);
      end
      check("almost full held", a_af, 1'b0);
      settle;
      check("almost full freed", {a_af, a_ff}, 2'h3);
      nxt = 17;
      for (k = 0; k < 7; k++)
      begin
         n = (t_sz[k] == `BFM_SZ_BYTE) ? 4 : (t_sz[k] == `BFM_SZ_WORD) ? 2 : 1;
         uw = 36 / n;
         mask = (36'h1 << uw) - 36'h1;
         xfer_b(1'b0, 1'b0, t_sz[k], t_be[k], 36'h0);
         hold = b_dout;
         for (u = 0; u < t_rd[k]; u++)
         begin
            xfer_b(1'b0, 1'b1, t_sz[k], t_be[k], 36'h0);
            exp = (val(nxt) >> (uw * (t_be[k] ? u : n - 1 - u))) & mask;
            check("narrow unit", b_dout & mask, exp);
            check("unused lanes", b_dout & ~mask, hold & ~mask);
         end
         nxt++;
      end
      xfer_a(1'b1, 1'b1, val(80));
      check("mail1 full", mailbox1_full_n, 1'b0);
      xfer_a(1'b1, 1'b1, val(81));
      xfer_b(1'b0, 1'b0, `BFM_SZ_MAIL, 1'b1, 36'h0);
      for (i = 0; i < 2; i++)
      begin
         xfer_b(1'b0, 1'b1, `BFM_SZ_MAIL, 1'b1, 36'h0);
         check("mail1 flags", {b_oe, mailbox1_full_n}, 2'h3);
         check("mail1 data", b_dout, val(80));
      end
      xfer_b(1'b1, 1'b1, `BFM_SZ_MAIL, 1'b1, val(82));
      check("mail2 full", {b_oe, mailbox2_full_n}, 2'h0);
      xfer_a(1'b0, 1'b1, 36'h0);
      check("mail2 flags", {a_oe, mailbox2_full_n}, 2'h3);
      check("mail2 data", a_dout, val(82));
      xfer_b(1'b1, 1'b0, `BFM_SZ_LONG, 1'b1, 36'h0);
      xfer_b(1'b1, 1'b1, `BFM_SZ_LONG, 1'b1, val(90));
      xfer_b(1'b1, 1'b1, `BFM_SZ_LONG, 1'b1, val(91));
      settle;
      check("queue 2 ready", a_ef, 1'b1);
      xfer_a(1'b0, 1'b0, 36'h0);
      check("queue 2 first", a_dout, val(90));
      xfer_a(1'b0, 1'b0, 36'h0);
      check("queue 2 last", {a_ef, a_dout}, {1'b0, val(91)});
      close_out;
   end
endmodule
